// [tb/unbm_checker.sv]
/*
  unbm_checker: port properties of the nine-bit serial port.
  assumes: bound onto unbm_uart; one clock, rst async high.
*/
`timescale 1ns/1ps
module unbm_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controls
  input wire logic rate_mode,
  input wire logic baud_doubler,
  input wire logic rx_enable,
  input wire logic tx_done_clear,
  input wire logic rx_done_clear,
  // pins and status
  input wire logic txd_out,
  input wire logic tx_busy,
  input wire logic rx_busy,
  input wire logic tx_done_flag,
  input wire logic rx_done_flag,
  input wire logic serial_irq
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // the line must never drop outside a frame
  idle_line_a: assert property (!tx_busy |-> txd_out)
    else $error("serial output low while idle");
  start_wait_a: assert property ($rose(tx_busy) |-> txd_out)
    else $error("start bit sent at once");
  done_on_stop_a: assert property ($rose(tx_done_flag) |-> txd_out && tx_busy)
    else $error("tx done away from stop bit");
  tx_sticky_a: assert property (tx_done_flag && !tx_done_clear |=> tx_done_flag)
    else $error("tx done dropped by itself");
  rx_sticky_a: assert property (rx_done_flag && !rx_done_clear |=> rx_done_flag)
    else $error("rx done dropped by itself");
  irq_mirror_a: assert property (serial_irq == (tx_done_flag || rx_done_flag))
    else $error("interrupt not tied to flags");
  // slow fixed rate: a low level after a fall lasts 64 clocks, 8 shown here
  bit_len_a: assert property (!rate_mode && !baud_doubler && $fell(txd_out)
    |-> !txd_out [*8])
    else $error("bit too short");
  rx_quiet_a: assert property (!rx_enable && !rx_busy |=> !rx_busy)
    else $error("receiver started while off");
endmodule

// [tb/unbm_node.sv]
/*
  unbm_node: far serial node, sends frames and watches the port.
  assumes: bench sets period in clocks before each frame.
*/
`timescale 1ns/1ps
module unbm_node (
  // clock
  input  wire logic clk,
  // serial lines
  input  wire logic txd_out,
  output logic      rxd_in
);
  int          period = 64;
  logic [10:0] got = 11'h000;
  initial rxd_in = 1'b1;
  // ****************
  // sender
  // ****************
  // whole frame lsb first, then back to idle high
  task automatic send(input logic [8:0] v, input logic stop_bit);
    logic [10:0] f;
    f = {stop_bit, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_in <= f[i];
      repeat (period) @(posedge clk);
    end
    rxd_in <= 1'b1;
  endtask
  // short low pulse, too brief to pass the start vote
  task automatic glitch();
    rxd_in <= 1'b0;
    repeat (4) @(posedge clk);
    rxd_in <= 1'b1;
  endtask
  // ****************
  // watcher
  // ****************
  // mid-bit sampling, so a wrong bit rate shows as wrong bits
  always begin
    @(negedge txd_out);
    repeat (period / 2) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      got[i] = txd_out;
      if (i < 10) repeat (period) @(posedge clk);
    end
  end
endmodule

// [tb/unbm_uart_bench.sv]
/*
  unbm_uart_bench: self-checking bench of the nine-bit serial port.
  assumes: unbm_node on the far side; timer pulses every 4 clocks.
*/
`timescale 1ns/1ps
module unbm_uart_bench;
  logic       clk = 1'b0, rst = 1'b1, rate_mode = 1'b0, baud_doubler = 1'b0;
  logic       tx_timer2_select = 1'b0, rx_timer2_select = 1'b0, rx_enable = 1'b0;
  logic       t1_overflow = 1'b0, t2_overflow = 1'b0, multiproc_enable = 1'b0;
  logic       tx_write = 1'b0, tx_ninth_bit = 1'b0, tx_done_clear = 1'b0;
  logic       rx_done_clear = 1'b0, rxd_in, txd_out, rx_ninth_bit, tx_done_flag;
  logic       rx_done_flag, serial_irq, tx_busy, rx_busy;
  logic [7:0] tx_data = 8'h00, serial_buffer;
  logic [1:0] tcnt = 2'h0;
  int         n_mismatch = 0, compares = 0;
  unbm_uart i_unbm_uart (.clk, .rst, .rate_mode, .baud_doubler, .tx_timer2_select,
    .rx_timer2_select, .t1_overflow, .t2_overflow, .rx_enable, .multiproc_enable,
    .tx_write, .tx_data, .tx_ninth_bit, .tx_done_clear, .rx_done_clear, .rxd_in,
    .txd_out, .serial_buffer, .rx_ninth_bit, .tx_done_flag, .rx_done_flag,
    .serial_irq, .tx_busy, .rx_busy);
  unbm_node i_unbm_node (.clk, .txd_out, .rxd_in);
  // ****************
  // clock and timer pulses
  // ****************
  always #2 clk = ~clk;
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    t1_overflow <= (tcnt == 2'h3);
    t2_overflow <= (tcnt == 2'h1);
  end
  // ****************
  // helpers
  // ****************
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic clear_flags();
    tx_done_clear <= 1'b1;
    rx_done_clear <= 1'b1;
    @(posedge clk);
    tx_done_clear <= 1'b0;
    rx_done_clear <= 1'b0;
    @(posedge clk);
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  // one frame out, judged by the node at mid-bit
  task automatic tx_frame(input logic [8:0] v, input int per);
    int n;
    i_unbm_node.period = per;
    {tx_ninth_bit, tx_data} <= v;
    tx_write <= 1'b1;
    @(posedge clk);
    tx_write <= 1'b0;
    n = 0;
    while (tx_done_flag !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n == 4000) n_mismatch++;
    repeat (per) @(posedge clk);
    check(i_unbm_node.got, {1'b1, v, 1'b0});
    check(11'(tx_done_flag), 11'h1);
    clear_flags();
    repeat (per) @(posedge clk);
  endtask
  // one frame in; take says whether it must be accepted
  task automatic rx_frame(input logic [8:0] v, input logic stop_bit, input logic take,
                          input int per);
    logic [8:0] old;
    logic       flag;
    old = {rx_ninth_bit, serial_buffer};
    flag = rx_done_flag | take;
    i_unbm_node.period = per;
    i_unbm_node.send(v, stop_bit);
    repeat (per) @(posedge clk);
    check(11'({rx_ninth_bit, serial_buffer}), 11'(take ? v : old));
    check(11'({rx_done_flag, serial_irq, rx_busy}), 11'({flag, flag, 1'b0}));
  endtask
  // ****************
  // main sequence and watchdog
  // ****************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(11'({txd_out, tx_done_flag, rx_done_flag}), 11'h4);
    tx_frame(9'h1A5, 64);
    baud_doubler <= 1'b1;
    tx_frame(9'h05A, 32);
    rate_mode <= 1'b1;
    tx_frame(9'h1C3, 64);
    baud_doubler <= 1'b0;
    tx_frame(9'h03C, 128);
    tx_timer2_select <= 1'b1;
    tx_frame(9'h1F0, 64);
    rx_enable <= 1'b1;
    rx_timer2_select <= 1'b1;
    rx_frame(9'h13C, 1'b1, 1'b1, 64);
    rx_frame(9'h0C3, 1'b1, 1'b0, 64);
    clear_flags();
    rate_mode <= 1'b0;
    baud_doubler <= 1'b1;
    rx_frame(9'h0E7, 1'b0, 1'b1, 32);
    clear_flags();
    baud_doubler <= 1'b0;
    multiproc_enable <= 1'b1;
    rx_frame(9'h055, 1'b1, 1'b0, 64);
    rx_frame(9'h1AA, 1'b1, 1'b1, 64);
    clear_flags();
    rx_frame(9'h166, 1'b0, 1'b0, 64);
    multiproc_enable <= 1'b0;
    rx_enable <= 1'b0;
    rx_frame(9'h199, 1'b1, 1'b0, 64);
    rx_enable <= 1'b1;
    i_unbm_node.glitch();
    repeat (128) @(posedge clk);
    check(11'({rx_done_flag, rx_busy}), 11'h0);
    rx_frame(9'h081, 1'b1, 1'b1, 64);
    complete_run();
  end
  // cut a hang well beyond the expected run
  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule
bind unbm_uart unbm_checker i_unbm_checker (.clk, .rst, .rate_mode, .baud_doubler,
  .rx_enable, .tx_done_clear, .rx_done_clear, .txd_out, .tx_busy, .rx_busy,
  .tx_done_flag, .rx_done_flag, .serial_irq);

// [verilog/unbm_pkg.sv]
/*
  unbm_pkg: shared constants for the nine-bit serial port.
  assumes: included ahead of every design file of the block.
*/
package unbm_pkg;
  // ************************************************************
  // frame and timing constants
  // ************************************************************
  localparam int          CLK_MHZ        = 250;
  localparam int          OVS_RATE       = 16;    // samples per bit
  localparam logic [3:0]  OVS_LAST       = 4'hF;  // last tick of a bit
  localparam logic [3:0]  VOTE_S1        = 4'h7;  // first vote sample
  localparam logic [3:0]  VOTE_S2        = 4'h8;
  localparam logic [3:0]  VOTE_S3        = 4'h9;  // decision point
  localparam logic [3:0]  DATA_BITS      = 4'h8;
  localparam logic [3:0]  FRAME_LAST     = 4'hA;  // start, 8 data, 9th, stop
  localparam logic [3:0]  RX_STOP_IDX    = 4'hA;
  localparam logic [3:0]  RX_NINTH_IDX   = 4'h9;
  // fixed rate: clk/64 per bit, clk/32 doubled; 16 ticks per bit
  localparam int          FIX_DIV_SLOW   = 64 / OVS_RATE;
  localparam int          FIX_DIV_FAST   = 32 / OVS_RATE;
  localparam logic [1:0]  FIX_CNT_SLOW   = 2'(FIX_DIV_SLOW - 1);
  localparam logic [1:0]  FIX_CNT_FAST   = 2'(FIX_DIV_FAST - 1);
  localparam logic        MODE_FIXED     = 1'b0;
  localparam logic        MODE_TIMER     = 1'b1;
endpackage

// [verilog/unbm_sync.sv]
/*
  unbm_sync: two-flop synchroniser for the serial input pin.
  assumes: input is asynchronous to clk; idles high.
*/
`timescale 1ns/1ps
module unbm_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // data
  input  wire logic din,
  output logic      dout
);
  // ************************************************************
  // synchroniser
  // ************************************************************
  logic meta;

  // resets high so the idle line shows no false start edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// [verilog/unbm_tick_gen.sv]
/*
  unbm_tick_gen: produces the 16x sample ticks for one direction.
  assumes: timer overflow inputs are single-cycle pulses on clk.
*/
`timescale 1ns/1ps
module unbm_tick_gen (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // rate selection
  input  wire logic rate_mode,
  input  wire logic baud_doubler,
  input  wire logic timer2_select,
  input  wire logic t1_overflow,
  input  wire logic t2_overflow,
  // output
  output logic      tick
);
  // ************************************************************
  // prescalers
  // ************************************************************
  logic [1:0] fix_cnt;
  logic       t1_half;
  logic       fix_end;
  logic       t1_use;
  logic       timer_tick;
  logic       next_tick;

  assign fix_end    = fix_cnt == (baud_doubler ? unbm_pkg::FIX_CNT_FAST
                                               : unbm_pkg::FIX_CNT_SLOW);
  // undoubled timer 1 is halved, so every other overflow counts
  assign t1_use     = t1_overflow && (baud_doubler || t1_half);
  assign timer_tick = timer2_select ? t2_overflow : t1_use;
  assign next_tick  = (rate_mode == unbm_pkg::MODE_FIXED) ? fix_end
                                                          : timer_tick;

  // fixed-rate divider and timer 1 halving flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fix_cnt <= 2'h0;
      t1_half <= 1'b0;
      tick    <= 1'b0;
    end else begin
      fix_cnt <= fix_end ? 2'h0 : fix_cnt + 2'h1;
      if (t1_overflow) t1_half <= ~t1_half;
      tick    <= next_tick;
    end
  end
endmodule

// [verilog/unbm_uart.sv]
/*
  unbm_uart: nine-bit asynchronous serial port, fixed and timer rates.
  holds: two tick generators, the pin synchroniser, the transmit and
  receive sequencers and the sticky status flags.
  assumes: control bits come from software logic on clk; clear and
  write strobes are one-cycle pulses; timer overflows are pulses;
  the serial input pin is asynchronous to clk and idles high.
*/
// Contract
// - frame is start, eight LSB-first, ninth, stop
// - sent ninth bit equals tx_ninth_bit input
// - fixed rate is clk/64, or clk/32 doubled
// - transmit starts at next divide-by-16 rollover
// - tx done raised as stop bit drives
// - receive enabled frame starts on falling edge
// - sixteen input samples per bit period
// - start edge resets receive sixteen-counter
// - each bit is majority of three mid-samples
// - failed start vote abandons frame
// - accept if rx done clear, stop high under multiproc
// - accept loads buffer, ninth bit, rx done
// - rejected frame leaves buffer and flags untouched
// - after mid stop, idle awaiting falling edge
// - timer mode same frames, timer-derived rate
// - multiproc raises interrupt only for ninth bit one
// - timer overflows feed divide-by-16 stage
// - doubler selects halving of timer 1 overflow
// - timer2 selects pick rate source per direction
// - baud doubler is power control bit 7
`timescale 1ns/1ps
module unbm_uart (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // configuration
  input  wire logic       rate_mode,
  input  wire logic       baud_doubler,
  input  wire logic       tx_timer2_select,
  input  wire logic       rx_timer2_select,
  input  wire logic       t1_overflow,
  input  wire logic       t2_overflow,
  input  wire logic       rx_enable,
  input  wire logic       multiproc_enable,
  // transmit side
  input  wire logic       tx_write,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_ninth_bit,
  input  wire logic       tx_done_clear,
  // receive side
  input  wire logic       rx_done_clear,
  // serial pins
  input  wire logic       rxd_in,
  output logic            txd_out,
  // status
  output logic [7:0]      serial_buffer,
  output logic            rx_ninth_bit,
  output logic            tx_done_flag,
  output logic            rx_done_flag,
  output logic            serial_irq,
  output logic            tx_busy,
  output logic            rx_busy
);
  // ************************************************************
  // rate ticks
  // ************************************************************
  logic tx_tick;
  logic rx_tick;
  logic rxd_s;

  // the doubler input stands for power control bit 7
  unbm_tick_gen u_tx_tick (
    .clk           (clk),
    .rst           (rst),
    .rate_mode     (rate_mode),
    .baud_doubler  (baud_doubler),
    .timer2_select (tx_timer2_select),
    .t1_overflow   (t1_overflow),
    .t2_overflow   (t2_overflow),
    .tick          (tx_tick)
  );

  // each direction owns its tick source, so the timer selects stay apart
  unbm_tick_gen u_rx_tick (
    .clk           (clk),
    .rst           (rst),
    .rate_mode     (rate_mode),
    .baud_doubler  (baud_doubler),
    .timer2_select (rx_timer2_select),
    .t1_overflow   (t1_overflow),
    .t2_overflow   (t2_overflow),
    .tick          (rx_tick)
  );

  // the pin passes two flops before the edge detector sees it
  unbm_sync u_rxd_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (rxd_in),
    .dout (rxd_s)
  );

  // ************************************************************
  // transmitter
  // ************************************************************
  // idle, waiting for the first rollover, then shifting the frame
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} unbm_tx_e;
  unbm_tx_e   tx_state;
  logic [3:0] tx_div;
  logic [3:0] tx_bit;
  logic [8:0] tx_shift;
  logic       tx_roll;
  logic       tx_stop_now;
  logic       next_txd;
  logic [3:0] tx_bit_inc;

  // the divide-by-16 counter free-runs so a write waits for its rollover
  assign tx_roll     = tx_tick && (tx_div == unbm_pkg::OVS_LAST);
  assign tx_stop_now = tx_roll && (tx_state == TX_SHIFT) &&
                       (tx_bit == unbm_pkg::FRAME_LAST - 4'h1);
  assign tx_bit_inc  = tx_bit + 4'h1;
  // level of the coming bit: 0 start, 1..8 data, 9 the ninth, 10 stop;
  // once data runs, the shifter keeps the bit due next in position 1
  assign next_txd    = (tx_bit_inc == unbm_pkg::FRAME_LAST) ? 1'b1 :
                       ((tx_bit == 4'h0) ? tx_shift[0] : tx_shift[1]);

  // transmit sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_div   <= 4'h0;
      tx_bit   <= 4'h0;
      tx_shift <= 9'h000;
      txd_out  <= 1'b1;
    end else begin
      // divider runs in every state, so rollovers stay evenly spaced
      if (tx_tick) tx_div <= tx_div + 4'h1;
      case (tx_state)
        TX_IDLE: begin
          txd_out <= 1'b1;
          if (tx_write) begin
            tx_shift <= {tx_ninth_bit, tx_data};
            tx_state <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (tx_roll) begin
            txd_out  <= 1'b0;
            tx_bit   <= 4'h0;
            tx_state <= TX_SHIFT;
          end
        end
        // the stop bit goes out on the rollover that ends the ninth bit
        TX_SHIFT: begin
          if (tx_roll) begin
            if (tx_bit == unbm_pkg::FRAME_LAST) begin
              txd_out  <= 1'b1;
              tx_state <= TX_IDLE;
            end else begin
              tx_bit  <= tx_bit_inc;
              txd_out <= next_txd;
              if (tx_bit != 4'h0) tx_shift <= {1'b1, tx_shift[8:1]};
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // ************************************************************
  // receiver
  // ************************************************************
  // frame position counts 0 start, 1..8 data, 9 ninth, 10 stop
  typedef enum logic [1:0] {RX_IDLE, RX_FRAME} unbm_rx_e;
  unbm_rx_e   rx_state;
  logic [3:0] rx_div;
  logic [3:0] rx_bit;
  logic [7:0] rx_shift;
  logic       rx_ninth;
  logic       rxd_prev;
  logic [1:0] votes;
  logic       vote;
  logic       rx_decide;
  logic       fall_edge;
  logic       accept;
  logic       rx_set;

  // the edge is looked for only on ticks, the sixteenfold sample points
  assign fall_edge = rxd_prev && !rxd_s;
  // two stored mid samples vote together with the live third one
  assign vote      = (votes[1] & votes[0]) | (votes[1] & rxd_s)
                   | (votes[0] & rxd_s);
  assign rx_decide = rx_tick && (rx_div == unbm_pkg::VOTE_S3);
  // stop must be high only when multiprocessor filtering is on
  assign accept    = !rx_done_flag && (!multiproc_enable || vote);
  // multiproc also drops frames whose ninth bit is zero
  assign rx_set    = (rx_state == RX_FRAME) && rx_decide &&
                     (rx_bit == unbm_pkg::RX_STOP_IDX) && accept &&
                     (!multiproc_enable || rx_ninth);

  // receive sequencer, one sample per tick
  // the start edge loads the counter with 1, the edge tick being sample 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_div   <= 4'h0;
      rx_bit   <= 4'h0;
      rx_shift <= 8'h00;
      rx_ninth <= 1'b0;
      rxd_prev <= 1'b1;
      votes    <= 2'h3;
    end else begin
      if (rx_tick) rxd_prev <= rxd_s;
      case (rx_state)
        RX_IDLE: begin
          if (rx_tick && rx_enable && fall_edge) begin
            rx_div   <= 4'h1;
            rx_bit   <= 4'h0;
            rx_state <= RX_FRAME;
          end
        end
        RX_FRAME: begin
          if (rx_tick) begin
            rx_div <= rx_div + 4'h1;
            if (rx_div == unbm_pkg::VOTE_S1) votes[1] <= rxd_s;
            if (rx_div == unbm_pkg::VOTE_S2) votes[0] <= rxd_s;
            if (rx_decide) begin
              if (rx_bit == 4'h0 && vote) rx_state <= RX_IDLE;
              else if (rx_bit == unbm_pkg::RX_STOP_IDX)
                rx_state <= RX_IDLE;
              else if (rx_bit == unbm_pkg::RX_NINTH_IDX)
                rx_ninth <= vote;
              else if (rx_bit != 4'h0)
                rx_shift <= {vote, rx_shift[7:1]};
              rx_bit <= rx_bit + 4'h1;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ************************************************************
  // visible status; a set beats a same-cycle clear
  // ************************************************************
  logic next_tx_done;
  logic next_rx_done;
  logic next_tx_busy;
  logic next_rx_busy;

  // a clear landing on the set cycle loses, so no event is missed
  assign next_tx_done = tx_stop_now || (tx_done_flag && !tx_done_clear);
  assign next_rx_done = rx_set || (rx_done_flag && !rx_done_clear);
  // a write counts as busy at once, so a second write sees it
  assign next_tx_busy = (tx_state != TX_IDLE) || tx_write;
  assign next_rx_busy = rx_state == RX_FRAME;

  // received word; buffer and ninth bit always move together
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_buffer <= 8'h00;
      rx_ninth_bit  <= 1'b0;
    end else if (rx_set) begin
      serial_buffer <= rx_shift;
      rx_ninth_bit  <= rx_ninth;
    end
  end

  // sticky done flags; only software pulses drop them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
    end else begin
      tx_done_flag <= next_tx_done;
      rx_done_flag <= next_rx_done;
    end
  end

  // interrupt built from the next flag values, so it never lags a clear;
  // a multiprocessor frame with ninth bit zero never sets rx done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_irq <= 1'b0;
    end else begin
      serial_irq <= next_tx_done || next_rx_done;
    end
  end

  // busy levels, one cycle behind the sequencers, except tx busy rising with the write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_busy <= 1'b0;
      rx_busy <= 1'b0;
    end else begin
      tx_busy <= next_tx_busy;
      rx_busy <= next_rx_busy;
    end
  end
endmodule
